/* logic/socket_pkg.sv */
// Constants and types for the socket force-event and power-control block.
// Assumes a 32-bit register port with byte offsets inside the socket window.
//
// Behaviour
// - Force address stores nothing, writes redirect
// - Forced caps hold switch until a revalidate or insertion reprobe ends
// - Force bits 31..15 read zero, ignore writes
// - Revalidate reprobes card, refreshes caps, enables power
// - Bits 13..10 write caps; ones disable power
// - Bits 9..7 write three status flags
// - Force bit 6 reserved, zero, no effect
// - Bits 5..4 write card type unless present
// - Bits 3..0 set events, present untouched
// - Control bits 31..8 and 3 read zero
// - Stop clock bit enables card clock stopping
// - Bits 6..4 encode supply voltage request
// - Bits 2..0 encode programming voltage request
// - CardBus card powered only at accepted voltages
// - Control at 10h, resets to zero
// - Invalid supply flag reports bad software request
// - X and Y socket capabilities read zero
`default_nettype none

package socket_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_PRESENT    = 8'h08;
  localparam logic [7:0] OFS_FORCE      = 8'h0C;
  localparam logic [7:0] OFS_CONTROL    = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h34;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h38;

  ////////////////////////////////////////////////////////////////////////
  // Force event field positions
  localparam int FE_REVALIDATE = 14;
  localparam int FE_CAP_LO     = 10;
  localparam int FE_INVALID    = 9;
  localparam int FE_DATA_LOSS  = 8;
  localparam int FE_UNRECOG    = 7;
  localparam int FE_CARDBUS    = 5;
  localparam int FE_LEGACY     = 4;
  localparam int EVT_W         = 4;
  localparam int CAP_W         = 4;

  // Event bit positions
  localparam int EVT_CSC = 0;
  localparam int EVT_CD1 = 1;
  localparam int EVT_CD2 = 2;
  localparam int EVT_PWR = 3;

  // Capability bit positions within a cap nibble
  localparam int CAP_5V0 = 0;
  localparam int CAP_3V3 = 1;
  localparam int CAP_X   = 2;
  localparam int CAP_Y   = 3;

  ////////////////////////////////////////////////////////////////////////
  // Voltage request codes
  localparam logic [2:0] V_OFF  = 3'h0;
  localparam logic [2:0] V_12V0 = 3'h1;
  localparam logic [2:0] V_5V0  = 3'h2;
  localparam logic [2:0] V_3V3  = 3'h3;
  localparam logic [2:0] V_X    = 3'h4;
  localparam logic [2:0] V_Y    = 3'h5;

  // Socket supply ability, order y, x, 3.3, 5.0
  localparam logic [3:0] SOCK_CAPS  = 4'h3;
  localparam logic [7:0] CTL_RESET  = 8'h00;

  // Card interrogation time and derived cycle count
  localparam int CLK_MHZ       = 25;
  localparam int PROBE_TIME_NS = 400;
  localparam int PROBE_CYCLES  = (PROBE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] PROBE_LAST = 8'(PROBE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Present state layout
  typedef struct packed {
    logic       socket_supplies_vcc_y;
    logic       socket_supplies_vcc_x;
    logic       socket_supplies_3v3;
    logic       socket_supplies_5v;
    logic [13:0] rsvd;
    logic [3:0] card_caps;
    logic       invalid_vcc_request;
    logic       removal_data_loss;
    logic       unrecognized_card;
    logic       ready_level;
    logic       cardbus_card_detected;
    logic       legacy_card_detected;
    logic       power_up_done;
    logic       card_detect_two;
    logic       card_detect_one;
    logic       card_status_change;
  } present_state_t;

  // Socket control layout (low byte)
  typedef struct packed {
    logic       stop_clock;
    logic [2:0] vcc_req;
    logic       rsvd;
    logic [2:0] vpp_req;
  } socket_ctl_t;

  typedef enum logic [1:0] {
    PWR_IDLE,
    PWR_PROBE,
    PWR_LATCH
  } pwr_state_t;

endpackage

`default_nettype wire

/* logic/socket_power_ctl.sv */
// Socket force-event redirection, present state and power request control.
// Assumes card pins are asynchronous and the power switch takes codes.
//
// The plain strobed port is this design's own decision.
`default_nettype none

module socket_power_ctl (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic        card_detect_one_b,
  input  wire logic        card_detect_two_b,
  input  wire logic        card_status_change_pin,
  input  wire logic        card_ready_pin,
  input  wire logic [3:0]  probe_caps,
  input  wire logic        probe_cardbus,
  output var  logic        probe_req,
  output var  logic [2:0]  vcc_sel,
  output var  logic [2:0]  vpp_sel,
  output var  logic        clock_stop_en,
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////
  // Acceptance of a supply code against card capabilities
  function automatic logic vcc_ok(input logic [2:0] code, input logic [3:0] caps);
    case (code)
      socket_pkg::V_OFF: vcc_ok = 1'b1;
      socket_pkg::V_5V0: vcc_ok = caps[socket_pkg::CAP_5V0];
      socket_pkg::V_3V3: vcc_ok = caps[socket_pkg::CAP_3V3];
      socket_pkg::V_X:   vcc_ok = caps[socket_pkg::CAP_X];
      socket_pkg::V_Y:   vcc_ok = caps[socket_pkg::CAP_Y];
      default:           vcc_ok = 1'b0;
    endcase
  endfunction

  // Valid programming voltage codes
  function automatic logic vpp_valid(input logic [2:0] code);
    vpp_valid = (code <= socket_pkg::V_Y);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int PIN_W = 9;
  // Empty-socket level after reset: detect pins high, so no false insertion
  localparam logic [PIN_W-1:0] PIN_IDLE = 9'h003;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [PIN_W-1:0] pin_raw;
  assign pin_raw = {probe_cardbus, probe_caps, card_ready_pin,
                    card_status_change_pin, card_detect_two_b, card_detect_one_b};

  // Two flops before any use
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  logic       cd1_b;
  logic       cd2_b;
  logic       csc_lvl;
  logic       ready_lvl;
  logic [3:0] caps_in;
  logic       cb_in;
  logic       card_present;
  assign cd1_b        = pin_sync[0];
  assign cd2_b        = pin_sync[1];
  assign csc_lvl      = pin_sync[2];
  assign ready_lvl    = pin_sync[3];
  assign caps_in      = pin_sync[7:4];
  assign cb_in        = pin_sync[8];
  assign card_present = ~cd1_b & ~cd2_b;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  logic wr_force;
  logic wr_ctl;
  logic wr_clr;
  logic wr_en;
  assign wr_force = reg_wr && (reg_addr == socket_pkg::OFS_FORCE);
  assign wr_ctl   = reg_wr && (reg_addr == socket_pkg::OFS_CONTROL);
  assign wr_clr   = reg_wr && (reg_addr == socket_pkg::OFS_IRQ_CLEAR);
  assign wr_en    = reg_wr && (reg_addr == socket_pkg::OFS_IRQ_ENABLE);

  logic revalidate;
  logic cap_force;
  assign revalidate = wr_force && reg_wdata[socket_pkg::FE_REVALIDATE];
  assign cap_force  = wr_force && (|reg_wdata[socket_pkg::FE_CAP_LO +: socket_pkg::CAP_W]);

  ////////////////////////////////////////////////////////////////////////
  // Socket control register, low byte stored only
  socket_pkg::socket_ctl_t ctl;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctl <= socket_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      ctl          <= reg_wdata[7:0];
      ctl.rsvd     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrogation sequencer
  socket_pkg::pwr_state_t state;
  logic [7:0] probe_cnt;
  logic       present_q;
  logic       insert_evt;
  assign insert_evt = card_present & ~present_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state     <= socket_pkg::PWR_IDLE;
      probe_cnt <= '0;
      probe_req <= 1'b0;
    end else begin
      probe_req <= 1'b0;
      case (state)
        socket_pkg::PWR_IDLE: begin
          if (revalidate || insert_evt) begin
            state     <= socket_pkg::PWR_PROBE;
            probe_cnt <= '0;
            probe_req <= 1'b1;
          end
        end
        socket_pkg::PWR_PROBE: begin
          if (probe_cnt == socket_pkg::PROBE_LAST) begin
            state <= socket_pkg::PWR_LATCH;
          end else begin
            probe_cnt <= probe_cnt + 8'h01;
          end
        end
        socket_pkg::PWR_LATCH: begin
          state <= socket_pkg::PWR_IDLE;
        end
        default: begin
          state <= socket_pkg::PWR_IDLE;
        end
      endcase
    end
  end

  logic probing;
  logic latch_caps;
  assign probing    = (state != socket_pkg::PWR_IDLE);
  assign latch_caps = (state == socket_pkg::PWR_LATCH);

  ////////////////////////////////////////////////////////////////////////
  // Power control enable
  logic pwr_ctl_en;
  logic caps_forced;

  // Caps forced since the last revalidate or insertion; a probe end must not unfreeze
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      caps_forced <= 1'b0;
    end else if (revalidate || insert_evt) begin
      caps_forced <= 1'b0;
    end else if (cap_force) begin
      caps_forced <= 1'b1;
    end
  end

  // Switch updates allowed
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwr_ctl_en <= 1'b1;
    end else if (revalidate || latch_caps) begin
      pwr_ctl_en <= latch_caps && (revalidate || (!caps_forced && !cap_force));
    end else if (cap_force) begin
      pwr_ctl_en <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Present state register
  socket_pkg::present_state_t ps;
  logic [2:0] next_vcc;
  logic       vcc_reject;
  logic       apply;
  // Other cards accept every defined supply code except 12 V
  localparam logic [3:0] ANY_CAPS = 4'hF;

  // Switch target; CardBus cards only at accepted voltages
  always_comb begin
    vcc_reject = !vcc_ok(ctl.vcc_req, ps.cardbus_card_detected ? ps.card_caps : ANY_CAPS);
    next_vcc   = vcc_reject ? socket_pkg::V_OFF : ctl.vcc_req;
  end
  assign apply = pwr_ctl_en && !probing;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ps                       <= '0;
      ps.socket_supplies_3v3   <= socket_pkg::SOCK_CAPS[1];
      ps.socket_supplies_5v    <= socket_pkg::SOCK_CAPS[0];
      ps.card_detect_two       <= 1'b1;
      ps.card_detect_one       <= 1'b1;
    end else begin
      ps.socket_supplies_vcc_y <= socket_pkg::SOCK_CAPS[3];
      ps.socket_supplies_vcc_x <= socket_pkg::SOCK_CAPS[2];
      ps.rsvd                  <= '0;
      ps.ready_level           <= ready_lvl;
      ps.card_status_change    <= csc_lvl;
      ps.power_up_done         <= (vcc_sel != socket_pkg::V_OFF);
      if (!probing) begin
        ps.card_detect_two <= cd2_b;
        ps.card_detect_one <= cd1_b;
      end
      if (apply) begin
        ps.invalid_vcc_request <= vcc_reject;
      end
      if (!card_present && present_q && vcc_sel != socket_pkg::V_OFF) begin
        ps.removal_data_loss <= 1'b1;
      end
      if (latch_caps) begin
        ps.card_caps             <= caps_in;
        ps.cardbus_card_detected <= cb_in;
        ps.legacy_card_detected  <= ~cb_in;
        ps.unrecognized_card     <= ~(|caps_in);
      end
      // Force writes land here; nothing of their own is kept
      if (wr_force) begin
        if (!reg_wdata[socket_pkg::FE_REVALIDATE]) begin
          ps.card_caps <= reg_wdata[socket_pkg::FE_CAP_LO +: socket_pkg::CAP_W];
        end
        ps.invalid_vcc_request <= reg_wdata[socket_pkg::FE_INVALID];
        ps.removal_data_loss   <= reg_wdata[socket_pkg::FE_DATA_LOSS];
        ps.unrecognized_card   <= reg_wdata[socket_pkg::FE_UNRECOG];
        if (!card_present) begin
          ps.cardbus_card_detected <= reg_wdata[socket_pkg::FE_CARDBUS];
          ps.legacy_card_detected  <= reg_wdata[socket_pkg::FE_LEGACY];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power switch and clock stop outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vcc_sel       <= socket_pkg::V_OFF;
      vpp_sel       <= socket_pkg::V_OFF;
      clock_stop_en <= 1'b0;
    end else begin
      clock_stop_en <= ctl.stop_clock;
      if (apply) begin
        vcc_sel <= next_vcc;
        vpp_sel <= vpp_valid(ctl.vpp_req) ? ctl.vpp_req : socket_pkg::V_OFF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event detection
  logic       cd1_q;
  logic       cd2_q;
  logic       csc_q;
  logic [2:0] vcc_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cd1_q     <= 1'b1;
      cd2_q     <= 1'b1;
      csc_q     <= 1'b0;
      vcc_q     <= socket_pkg::V_OFF;
      present_q <= 1'b0;
    end else begin
      cd1_q     <= cd1_b;
      cd2_q     <= cd2_b;
      csc_q     <= csc_lvl;
      vcc_q     <= vcc_sel;
      present_q <= card_present;
    end
  end

  logic [socket_pkg::EVT_W-1:0] evt_set;

  always_comb begin
    evt_set                      = '0;
    evt_set[socket_pkg::EVT_CSC] = csc_lvl & ~csc_q;
    evt_set[socket_pkg::EVT_CD1] = (cd1_b != cd1_q) & ~probing;
    evt_set[socket_pkg::EVT_CD2] = (cd2_b != cd2_q) & ~probing;
    evt_set[socket_pkg::EVT_PWR] = (vcc_sel != vcc_q);
    if (wr_force) begin
      evt_set = evt_set | reg_wdata[socket_pkg::EVT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky event status, enable, interrupt
  logic [socket_pkg::EVT_W-1:0] evt_status;
  logic [socket_pkg::EVT_W-1:0] evt_enable;

  // Set beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      evt_status <= '0;
    end else begin
      evt_status <= (evt_status & ~(wr_clr ? reg_wdata[socket_pkg::EVT_W-1:0] : '0))
                    | evt_set;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      evt_enable <= '0;
    end else if (wr_en) begin
      evt_enable <= reg_wdata[socket_pkg::EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe only
  logic [31:0] rd_mux;

  always_comb begin
    case (reg_addr)
      socket_pkg::OFS_PRESENT:    rd_mux = ps;
      socket_pkg::OFS_FORCE:      rd_mux = '0;
      socket_pkg::OFS_CONTROL:    rd_mux = {24'h000000, ctl};
      socket_pkg::OFS_IRQ_STATUS: rd_mux = {28'h0000000, evt_status};
      socket_pkg::OFS_IRQ_ENABLE: rd_mux = {28'h0000000, evt_enable};
      default:                    rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

endmodule

`default_nettype wire

/* testbench/socket_power_ctl_assertions.sv */
// Port checker for the socket power control block.
// Assumes one clock and the package register map.
`default_nettype none

module socket_power_ctl_assertions (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        probe_req,
  input wire logic [2:0]  vcc_sel,
  input wire logic [2:0]  vpp_sel,
  input wire logic        clock_stop_en
);
  logic       fw;
  logic       held;
  logic [7:0] busy;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Force write decode
  assign fw = reg_wr && reg_addr == socket_pkg::OFS_FORCE;

  // Holdoff window after forced capabilities
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      held <= 1'h0;
    end else if (probe_req || (fw && reg_wdata[14])) begin
      held <= 1'h0;
    end else if (fw && |reg_wdata[13:10]) begin
      held <= 1'h1;
    end
  end

  // Interrogation in progress after a probe pulse; a revalidate then is absorbed
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 8'h00;
    end else if (probe_req) begin
      busy <= 8'(socket_pkg::PROBE_CYCLES);
    end else if (busy != 8'h00) begin
      busy <= busy - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_force_read_zero: assert property (
    reg_rd && reg_addr == socket_pkg::OFS_FORCE |=> reg_rdata == 32'h0)
    else $error("force address read not zero");
  a_ctl_rsvd_zero: assert property (
    reg_rd && reg_addr == socket_pkg::OFS_CONTROL |=> reg_rdata[31:8] == 24'h0 && !reg_rdata[3])
    else $error("control reserved bits set");
  a_reval_probe_start: assert property (
    fw && reg_wdata[14] && !probe_req && busy == 8'h00 |=> ##[0:1] probe_req)
    else $error("revalidate did not start probe");
  a_probe_one_cycle: assert property (probe_req |=> !probe_req)
    else $error("probe pulse too long");
  a_stop_clock_copy: assert property (
    reg_wr && reg_addr == socket_pkg::OFS_CONTROL |-> ##2 clock_stop_en == $past(reg_wdata[7], 2))
    else $error("clock stop enable mismatch");
  a_vcc_code_legal: assert property (!(vcc_sel inside {3'h1, 3'h6, 3'h7}))
    else $error("reserved supply code on switch");
  a_vpp_code_legal: assert property (vpp_sel < 3'h6)
    else $error("reserved programming code on switch");
  a_forced_switch_hold: assert property (
    held && $past(held, 2) |-> $stable(vcc_sel) && $stable(vpp_sel))
    else $error("switch changed during holdoff");

  // Main scenarios reached
  c_probe: cover property (probe_req);
  c_stop: cover property (clock_stop_en);
  c_hold: cover property (held);
endmodule

bind socket_power_ctl socket_power_ctl_assertions u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .probe_req(probe_req), .vcc_sel(vcc_sel), .vpp_sel(vpp_sel),
  .clock_stop_en(clock_stop_en));

`default_nettype wire

/* testbench/pc_card_model.sv */
// PC Card model seen at the socket pins.
// Assumes the bench drives inserted after a clock edge.
`default_nettype none

module pc_card_model #(
  parameter logic [3:0] CAPS  = 4'h3,
  parameter logic       IS_CB = 1'h1
) (
  input  wire logic       inserted,
  output wire logic       card_detect_one_b,
  output wire logic       card_detect_two_b,
  output wire logic       card_status_change_pin,
  output wire logic       card_ready_pin,
  output wire logic [3:0] probe_caps,
  output wire logic       probe_cardbus
);
  // Detect pins pulled up while the socket is empty
  assign card_detect_one_b = !inserted;
  assign card_detect_two_b = !inserted;
  assign card_status_change_pin = 1'h0;
  assign card_ready_pin = inserted;
  // Probe lines show the inverse when nothing answers
  assign probe_caps = inserted ? CAPS : ~CAPS;
  assign probe_cardbus = inserted ? IS_CB : !IS_CB;
endmodule

`default_nettype wire

/* testbench/socket_power_ctl_bench.sv */
// Self-checking bench for socket force events and power control.
// Assumes one clock and a CardBus card model on the pin side.
`default_nettype none

module socket_power_ctl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PRS = socket_pkg::OFS_PRESENT;
  localparam logic [7:0] FRC = socket_pkg::OFS_FORCE;
  localparam logic [7:0] CTL = socket_pkg::OFS_CONTROL;
  logic        clk_sys = 1'h0;
  logic        rst_b = 1'h0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        inserted = 1'h0;
  logic [31:0] reg_rdata;
  logic        cd1_b, cd2_b, csc, rdy, pcb, probe_req, clock_stop_en, irq;
  logic [3:0]  caps;
  logic [2:0]  vcc_sel, vpp_sel;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          probes = 0;

  socket_power_ctl u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .card_detect_one_b(cd1_b), .card_detect_two_b(cd2_b), .card_status_change_pin(csc),
    .card_ready_pin(rdy), .probe_caps(caps), .probe_cardbus(pcb), .probe_req(probe_req),
    .vcc_sel(vcc_sel), .vpp_sel(vpp_sel), .clock_stop_en(clock_stop_en), .irq(irq));
  pc_card_model u_card (.inserted(inserted), .card_detect_one_b(cd1_b),
    .card_detect_two_b(cd2_b), .card_status_change_pin(csc), .card_ready_pin(rdy),
    .probe_caps(caps), .probe_cardbus(pcb));

  ////////////////////////////////////////////////////////////
  // Clock and probe counting
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (probe_req === 1'h1) probes <= probes + 1;

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    @(negedge clk_sys);
    cmp(reg_rdata, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic summarize;
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    #100000;
    miscompares++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'h1;
    chk(CTL, 32'h0);
    chk(PRS, 32'h3000_0006);
    wr(CTL, 32'hFFFF_FFFF);
    chk(CTL, 32'h0000_00F7);
    settle(3);
    cmp({29'h0, vcc_sel}, 32'h0);
    cmp({29'h0, vpp_sel}, 32'h0);
    cmp({31'h0, clock_stop_en}, 32'h1);
    wr(CTL, 32'h0);
    wr(FRC, 32'hFFFF_BFF0);
    chk(FRC, 32'h0);
    chk(PRS, 32'h3000_3FB6);
    wr(CTL, 32'h0000_0020);
    settle(4);
    cmp({29'h0, vcc_sel}, 32'h0);
    @(posedge clk_sys);
    inserted <= 1'h1;
    settle(30);
    chk(PRS, 32'h3000_0D68);
    cmp({29'h0, vcc_sel}, 32'h2);
    wr(8'h38, 32'h0);
    wr(8'h34, 32'hF);
    wr(FRC, 32'h0000_0C0F);
    chk(8'h30, 32'hF);
    chk(PRS, 32'h3000_0C68);
    cmp({31'h0, irq}, 32'h0);
    wr(8'h38, 32'hF);
    settle(3);
    cmp({31'h0, irq}, 32'h1);
    wr(8'h34, 32'hF);
    settle(3);
    cmp({31'h0, irq}, 32'h0);
    wr(CTL, 32'h0000_0030);
    settle(4);
    cmp({29'h0, vcc_sel}, 32'h2);
    wr(FRC, 32'h0000_4000);
    settle(20);
    cmp({29'h0, vcc_sel}, 32'h3);
    cmp(32'(probes), 32'h2);
    for (int c = 0; c < 8; c++) begin
      wr(CTL, {25'h0, 3'(c), 1'h0, 3'(c)});
      settle(3);
      cmp({29'h0, vcc_sel}, (c == 2 || c == 3) ? 32'(c) : 32'h0);
      cmp({29'h0, vpp_sel}, (c < 6) ? 32'(c) : 32'h0);
    end
    chk(PRS, 32'h3000_0E60);
    cmp({31'h0, clock_stop_en}, 32'h0);
    wr(8'h44, 32'hFFFF_FFFF);
    chk(8'h44, 32'h0);
    summarize();
  end
endmodule

`default_nettype wire
